// File: hdl/endpoint_end.sv
// Purpose: endpoint end: offers width/rate, answers config, sources upstream traffic
// Assumes: root port keeps its rules
// Notes: user may force retry status to exercise reissue
`timescale 1ns/1ps
module endpoint_end
   import link_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Capabilities
   input wire logic dev_present,
   input wire logic [4:0] dev_lanes,
   input wire logic [2:0] dev_rates,
   input wire logic cfg_retry,
   // Upstream request from user
   input wire logic usr_valid,
   output logic usr_ready,
   input wire link_pkg::tlp_t usr_kind,
   input wire logic [link_pkg::ADDR_W-1:0] usr_addr,
   input wire logic [link_pkg::WORD_W-1:0] usr_data,
   // Downstream seen by user
   output logic rx_valid,
   output link_pkg::tlp_s_t rx_tlp,
   output logic [2:0] ep_enc,
   // Link
   link_if.endpt lnk
);
   import link_pkg::*;
   logic cpl_pend_reg;
   tlp_s_t cpl_reg;
   logic [WORD_W-1:0] cfg_mem_reg [CFG_SPACE_BYTES/4];
   assign lnk.present = dev_present;
   assign lnk.lanes_offered = dev_lanes;
   assign lnk.rates_offered = dev_rates;
   assign ep_enc = {2'b00, lnk.enc};
   assign lnk.dn_ready = lnk.link_up && !cpl_pend_reg;
   assign lnk.up_valid = cpl_pend_reg || (usr_valid && lnk.link_up);
   assign lnk.up_tlp = cpl_pend_reg ? cpl_reg
      : '{kind: usr_kind, addr: usr_addr, data: usr_data, no_snoop: 1'b0, relaxed: 1'b0,
          peer: 1'b0, vc: 3'h0, status: CPL_OK};
   assign usr_ready = lnk.up_ready && !cpl_pend_reg && lnk.link_up;
   always_ff @(posedge clk) begin
      if (lnk.dn_valid && lnk.dn_ready && lnk.dn_tlp.kind == TLP_CFG_WR && !cfg_retry) begin
         cfg_mem_reg[lnk.dn_tlp.addr[11:2]] <= lnk.dn_tlp.data;
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cpl_pend_reg <= 1'b0;
         cpl_reg <= '0;
         rx_valid <= 1'b0;
         rx_tlp <= '0;
      end else begin
         rx_valid <= lnk.dn_valid && lnk.dn_ready;
         if (lnk.dn_valid && lnk.dn_ready) rx_tlp <= lnk.dn_tlp;
         if (cpl_pend_reg && lnk.up_ready) cpl_pend_reg <= 1'b0;
         else if (lnk.dn_valid && lnk.dn_ready &&
                  (lnk.dn_tlp.kind == TLP_CFG_RD || lnk.dn_tlp.kind == TLP_CFG_WR)) begin
            cpl_pend_reg <= 1'b1;
            cpl_reg <= '{kind: TLP_CPL, addr: lnk.dn_tlp.addr, data: cfg_mem_reg[lnk.dn_tlp.addr[11:2]],
                         no_snoop: 1'b0, relaxed: 1'b0, peer: 1'b0, vc: 3'h0,
                         status: cfg_retry ? CPL_RETRY : CPL_OK};
         end
      end
   end
endmodule

// File: hdl/link_if.sv
// Purpose: carrier joining root port and endpoint
// Assumes: both ends on clk
// Notes: transaction-level packets with valid/ready each way
`timescale 1ns/1ps
interface link_if;
   import link_pkg::*;
   logic present;
   logic [4:0] lanes_offered;
   logic [2:0] rates_offered;
   logic train_req;
   width_t width;
   rate_t rate;
   enc_t enc;
   logic link_up;
   tlp_s_t dn_tlp;
   logic dn_valid;
   logic dn_ready;
   tlp_s_t up_tlp;
   logic up_valid;
   logic up_ready;
   modport root (input present, input lanes_offered, input rates_offered, output train_req,
      output width, output rate, output enc, output link_up, output dn_tlp, output dn_valid,
      input dn_ready, input up_tlp, input up_valid, output up_ready);
   modport endpt (output present, output lanes_offered, output rates_offered, input train_req,
      input width, input rate, input enc, input link_up, input dn_tlp, input dn_valid,
      output dn_ready, output up_tlp, output up_valid, input up_ready);
endinterface

// File: hdl/link_pkg.sv
// Purpose: shared constants and types for the root port and endpoint ends
// Assumes: one 20 MHz clock, transaction-level link model
// Notes: lane/rate codes are carried as plain fields on the link
package link_pkg;
   localparam int WORD_W = 32;
   localparam int ADDR_W = 64;
   localparam int ADDR_LIMIT_BIT = 36;
   localparam int FIFO_DEPTH = 4;
   localparam int CFG_SPACE_BYTES = 4096;
   localparam int CFG_LEGACY_BYTES = 256;
   localparam logic [11:0] CFG_EXT_BASE = 12'h100;
   localparam int MAX_LANES = 16;
   localparam int MAX_CFG_RETRY = 8;
   localparam int TRAIN_TIME_NS = 1000;
   localparam int CLK_PERIOD_NS = 50;
   localparam int TRAIN_CYCLES = (TRAIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      W_X1 = 3'h0,
      W_X2 = 3'h1,
      W_X4 = 3'h2,
      W_X8 = 3'h3,
      W_X16 = 3'h4
   } width_t;

   typedef enum logic [1:0] {
      GEN1 = 2'h0,
      GEN2 = 2'h1,
      GEN3 = 2'h2
   } rate_t;

   typedef enum logic [0:0] {
      ENC_8B10B = 1'h0,
      ENC_128B130B = 1'h1
   } enc_t;

   typedef enum logic [2:0] {
      TLP_MEM_RD = 3'h0,
      TLP_MEM_WR = 3'h1,
      TLP_CFG_RD = 3'h2,
      TLP_CFG_WR = 3'h3,
      TLP_MSG_MSI = 3'h4,
      TLP_CPL = 3'h5
   } tlp_t;

   typedef enum logic [1:0] {
      CPL_OK = 2'h0,
      CPL_UR = 2'h1,
      CPL_RETRY = 2'h2
   } cpl_t;

   typedef struct packed {
      tlp_t kind;
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] data;
      logic no_snoop;
      logic relaxed;
      logic peer;
      logic [2:0] vc;
      cpl_t status;
   } tlp_s_t;

   localparam int TLP_W = $bits(tlp_s_t);
endpackage

// File: hdl/root_port.sv
// Purpose: root port end: training, config translation, address limits, ordering
// Assumes: endpoint end keeps its rules; host issues one config access at a time
// Notes: the downstream path passes through a 4-word FIFO
// Function
// - Train up to x16, fall back narrower
// - Three rates chosen at negotiation
// - Gen1 and Gen2 use 8b/10b coding
// - Gen3 uses 128b/130b coding
// - 4 KB config space, extended from 100h
// - Legacy region via both access methods
// - Memory-mapped config becomes config requests
// - Software uses aligned 32-bit config accesses
// - Downstream addresses never reach 64 GB
// - Upstream reads above 64 GB get UR
// - Upstream writes above 64 GB dropped
// - Retry status config requests reissued
// - Peer traffic only posted writes, VC0
// - Snooped strict and non-snooped relaxed traffic
// - Training starts automatically after reset
// - Link presented as a bridge hierarchy
// - Accept MSI and MSI-X messages
// - No hot-plug handling
`timescale 1ns/1ps
module root_port
   import link_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Host memory/config requests
   input wire logic host_valid,
   output logic host_ready,
   input wire logic host_write,
   input wire logic host_cfg,
   input wire logic host_legacy_cfg,
   input wire logic [link_pkg::ADDR_W-1:0] host_addr,
   input wire logic [link_pkg::WORD_W-1:0] host_wdata,
   input wire logic host_no_snoop,
   input wire logic host_peer,
   // Host answers
   output logic cfg_done,
   output logic [link_pkg::WORD_W-1:0] cfg_rdata,
   output logic cfg_error,
   // Upstream toward memory
   output logic mem_wr_valid,
   output logic [link_pkg::ADDR_W-1:0] mem_wr_addr,
   output logic [link_pkg::WORD_W-1:0] mem_wr_data,
   output logic ur_sent,
   output logic wr_dropped,
   output logic msi_valid,
   output logic [link_pkg::WORD_W-1:0] msi_data,
   // Status
   output link_pkg::width_t link_width,
   output link_pkg::rate_t link_rate,
   output logic link_trained,
   // Link
   link_if.root lnk
);
   import link_pkg::*;

   typedef enum logic [3:0] {
      S_DETECT = 4'b0001,
      S_TRAIN = 4'b0010,
      S_UP = 4'b0100,
      S_CFG_WAIT = 4'b1000
   } state_t;

   state_t state_reg;
   logic [$clog2(TRAIN_CYCLES+1)-1:0] train_cnt_reg;
   width_t width_reg;
   rate_t rate_reg;
   tlp_s_t cfg_tlp_reg;
   logic [3:0] retry_cnt_reg;
   tlp_s_t dn_in;
   logic dn_in_valid;
   logic dn_in_ready;
   logic [TLP_W-1:0] dn_out;
   logic cfg_issue_reg;
   logic up_is_cpl;
   logic up_high;
   logic peer_rd;
   logic ur_pend_reg;

   // Widest common width and fastest common rate
   function automatic width_t pick_width(input logic [4:0] offered);
      if (offered[4]) return W_X16;
      else if (offered[3]) return W_X8;
      else if (offered[2]) return W_X4;
      else if (offered[1]) return W_X2;
      else return W_X1;
   endfunction

   function automatic rate_t pick_rate(input logic [2:0] offered);
      if (offered[2]) return GEN3;
      else if (offered[1]) return GEN2;
      else return GEN1;
   endfunction

   // Training runs from reset with no software step; no hot-plug, so a lost endpoint is not retrained
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= S_DETECT;
         train_cnt_reg <= '0;
         width_reg <= W_X1;
         rate_reg <= GEN1;
      end else begin
         case (state_reg)
            S_DETECT: begin
               if (lnk.present) begin
                  state_reg <= S_TRAIN;
                  train_cnt_reg <= '0;
               end
            end
            S_TRAIN: begin
               if (train_cnt_reg == ($bits(train_cnt_reg))'(TRAIN_CYCLES - 1)) begin
                  width_reg <= pick_width(lnk.lanes_offered);
                  rate_reg <= pick_rate(lnk.rates_offered);
                  state_reg <= S_UP;
               end else begin
                  train_cnt_reg <= train_cnt_reg + 1'b1;
               end
            end
            S_UP: begin
               if (host_valid && host_cfg && dn_in_ready) state_reg <= S_CFG_WAIT;
            end
            S_CFG_WAIT: begin
               if (lnk.up_valid && lnk.up_tlp.kind == TLP_CPL &&
                   (lnk.up_tlp.status != CPL_RETRY || retry_cnt_reg == 4'(MAX_CFG_RETRY))) begin
                  state_reg <= S_UP;
               end
            end
            default: state_reg <= S_DETECT;
         endcase
      end
   end

   assign lnk.train_req = (state_reg == S_TRAIN);
   assign lnk.width = width_reg;
   assign lnk.rate = rate_reg;
   assign lnk.enc = (rate_reg == GEN3) ? ENC_128B130B : ENC_8B10B;
   assign lnk.link_up = (state_reg == S_UP) || (state_reg == S_CFG_WAIT);
   assign link_width = width_reg;
   assign link_rate = rate_reg;
   assign link_trained = lnk.link_up;

   // Host request to a downstream packet; config offsets stay inside the 4 KB function space
   always_comb begin
      dn_in = '0;
      dn_in.no_snoop = host_no_snoop;
      dn_in.relaxed = host_no_snoop;
      dn_in.peer = host_peer && host_write && !host_cfg;
      dn_in.vc = 3'h0;
      dn_in.data = host_wdata;
      dn_in.addr = {{(ADDR_W-ADDR_LIMIT_BIT){1'b0}}, host_addr[ADDR_LIMIT_BIT-1:0]};
      if (host_cfg) begin
         // Legacy port path and flat memory-mapped path both land here
         dn_in.kind = host_write ? TLP_CFG_WR : TLP_CFG_RD;
         dn_in.addr[11:0] = host_legacy_cfg ? {4'h0, host_addr[7:2], 2'b00}
                                            : {host_addr[11:2], 2'b00};
      end else begin
         dn_in.kind = host_write ? TLP_MEM_WR : TLP_MEM_RD;
      end
   end

   // Peer reads are refused at the host port
   // Config never counts as peer, else it would wait for a completion that never comes
   assign peer_rd = host_peer && !host_write && !host_cfg;
   assign dn_in_valid = cfg_issue_reg || (state_reg == S_UP && host_valid && !peer_rd);
   assign host_ready = (state_reg == S_UP) && !cfg_issue_reg && (dn_in_ready || peer_rd);

   // Config retry: hold the request and send it again
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_tlp_reg <= '0;
         retry_cnt_reg <= '0;
         cfg_issue_reg <= 1'b0;
      end else begin
         if (state_reg == S_UP && host_valid && host_cfg && dn_in_ready) begin
            cfg_tlp_reg <= dn_in;
            retry_cnt_reg <= '0;
         end
         if (cfg_issue_reg && dn_in_ready) cfg_issue_reg <= 1'b0;
         if (state_reg == S_CFG_WAIT && lnk.up_valid && lnk.up_tlp.kind == TLP_CPL &&
             lnk.up_tlp.status == CPL_RETRY && retry_cnt_reg != 4'(MAX_CFG_RETRY)) begin
            cfg_issue_reg <= 1'b1;
            retry_cnt_reg <= retry_cnt_reg + 1'b1;
         end
      end
   end

   tlp_fifo #(.WIDTH(TLP_W), .DEPTH(FIFO_DEPTH)) dn_fifo (
      .clk(clk),
      .reset_n(reset_n),
      .in_data(cfg_issue_reg ? cfg_tlp_reg : dn_in),
      .in_valid(dn_in_valid),
      .in_ready(dn_in_ready),
      .out_data(dn_out),
      .out_valid(lnk.dn_valid),
      .out_ready(lnk.dn_ready)
   );
   assign lnk.dn_tlp = tlp_s_t'(dn_out);

   // Upstream handling
   assign up_is_cpl = lnk.up_tlp.kind == TLP_CPL;
   assign up_high = |lnk.up_tlp.addr[ADDR_W-1:ADDR_LIMIT_BIT];
   assign lnk.up_ready = !ur_pend_reg;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_done <= 1'b0;
         cfg_rdata <= '0;
         cfg_error <= 1'b0;
         mem_wr_valid <= 1'b0;
         mem_wr_addr <= '0;
         mem_wr_data <= '0;
         wr_dropped <= 1'b0;
         msi_valid <= 1'b0;
         msi_data <= '0;
      end else begin
         cfg_done <= 1'b0;
         mem_wr_valid <= 1'b0;
         wr_dropped <= 1'b0;
         msi_valid <= 1'b0;
         if (lnk.up_valid && !ur_pend_reg) begin
            if (up_is_cpl && state_reg == S_CFG_WAIT &&
                (lnk.up_tlp.status != CPL_RETRY || retry_cnt_reg == 4'(MAX_CFG_RETRY))) begin
               cfg_done <= 1'b1;
               cfg_rdata <= lnk.up_tlp.data;
               cfg_error <= lnk.up_tlp.status != CPL_OK;
            end else if (lnk.up_tlp.kind == TLP_MEM_WR) begin
               if (up_high) begin
                  wr_dropped <= 1'b1;
               end else begin
                  mem_wr_valid <= 1'b1;
                  mem_wr_addr <= lnk.up_tlp.addr;
                  mem_wr_data <= lnk.up_tlp.data;
               end
            end else if (lnk.up_tlp.kind == TLP_MSG_MSI) begin
               msi_valid <= 1'b1;
               msi_data <= lnk.up_tlp.data;
            end
         end
      end
   end

   // UR answers bypass the FIFO; up_ready stalls while one is pending
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ur_pend_reg <= 1'b0;
      end else if (ur_pend_reg) begin
         ur_pend_reg <= 1'b0;
      end else if (lnk.up_valid && lnk.up_tlp.kind == TLP_MEM_RD && up_high) begin
         ur_pend_reg <= 1'b1;
      end
   end
   assign ur_sent = ur_pend_reg;
endmodule

// File: hdl/tlp_fifo.sv
// Purpose: small flop FIFO with valid/ready on both sides
// Assumes: single clock
// Notes: depth must be a power of two
`timescale 1ns/1ps
module tlp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Fill side
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // Drain side
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   // Pointer wrap relies on a power-of-two depth
   if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("tlp_fifo DEPTH must be a power of two");
   end
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0] wr_reg;
   logic [AW:0] rd_reg;
   logic push;
   logic pop;
   assign in_ready = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
   assign out_valid = wr_reg != rd_reg;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_reg[rd_reg[AW-1:0]];
   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_reg[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         if (push) wr_reg <= wr_reg + 1'b1;
         if (pop) rd_reg <= rd_reg + 1'b1;
      end
   end
endmodule

// File: sim/link_assertions.sv
// Purpose: link checks between root port and endpoint
// Assumes: one clock, interface signals as inputs
// Notes: widest lanes and fastest rate offered win
`timescale 1ns/1ps
module link_assertions (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Link
   input wire logic present,
   input wire logic [4:0] lanes_offered,
   input wire logic [2:0] rates_offered,
   input wire logic link_up,
   input wire link_pkg::width_t width,
   input wire link_pkg::rate_t rate,
   input wire link_pkg::enc_t enc,
   input wire link_pkg::tlp_s_t dn_tlp,
   input wire logic dn_valid,
   input wire link_pkg::tlp_s_t up_tlp,
   input wire logic up_valid,
   input wire logic up_ready
);
   import link_pkg::*;
   function automatic int top_bit(input logic [4:0] v);
      top_bit = 0;
      for (int i = 0; i < 5; i++) if (v[i]) top_bit = i;
   endfunction
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_width; link_up |-> int'(width) == top_bit(lanes_offered); endproperty
   a_width: assert property (p_width) else $error("width not widest offered");
   property p_rate; link_up |-> int'(rate) == top_bit({2'h0, rates_offered}); endproperty
   a_rate: assert property (p_rate) else $error("rate not fastest offered");
   property p_enc_low; link_up && rate != GEN3 |-> enc == ENC_8B10B; endproperty
   a_enc_low: assert property (p_enc_low) else $error("low rate coding wrong");
   property p_enc_hi; link_up && rate == GEN3 |-> enc == ENC_128B130B; endproperty
   a_enc_hi: assert property (p_enc_hi) else $error("gen3 coding wrong");
   property p_dn_addr; dn_valid |-> dn_tlp.addr[63:36] == 28'h0; endproperty
   a_dn_addr: assert property (p_dn_addr) else $error("downstream address too high");
   property p_up_ur; up_valid && up_ready && up_tlp.kind == TLP_MEM_RD && up_tlp.addr[63:36] != 28'h0 |=> !up_ready;
   endproperty
   a_up_ur: assert property (p_up_ur) else $error("high read not refused");
   property p_peer; dn_valid && dn_tlp.peer |-> dn_tlp.kind == TLP_MEM_WR && dn_tlp.vc == 3'h0; endproperty
   a_peer: assert property (p_peer) else $error("peer traffic not posted vc0");
   property p_train; present |-> ##[0:40] link_up; endproperty
   a_train: assert property (p_train) else $error("link did not train");
   property p_stay; link_up |=> link_up; endproperty
   a_stay: assert property (p_stay) else $error("link dropped");
endmodule

// File: sim/testbench.sv
// Purpose: self-checking bench for both link ends
// Assumes: endpoint answers config reads itself
// Notes: fixed seed, random traffic with corner cases
`timescale 1ns/1ps
module testbench;
   import link_pkg::*;
   logic clk, reset_n, host_valid, host_ready, host_write, host_cfg, host_legacy_cfg, host_no_snoop, host_peer;
   logic [ADDR_W-1:0] host_addr, usr_addr, mem_wr_addr, a;
   logic [WORD_W-1:0] host_wdata, usr_data, cfg_rdata, mem_wr_data, msi_data;
   logic cfg_done, cfg_error, mem_wr_valid, ur_sent, wr_dropped, msi_valid, link_trained;
   logic dev_present, cfg_retry, usr_valid, usr_ready, rx_valid;
   logic [4:0] dev_lanes, lanes;
   logic [2:0] dev_rates, ep_enc, rates;
   logic [27:0] hi;
   logic [31:0] d0, d1;
   width_t link_width;
   rate_t link_rate;
   tlp_t usr_kind;
   tlp_s_t rx_tlp, e;
   int err_total, comparisons, seed, n_wr, n_drop, n_ur, n_msi, n_cfg;
   tlp_s_t exp_q[$];
   link_if lnk();
   root_port root_port_i (.clk, .reset_n, .host_valid, .host_ready, .host_write, .host_cfg, .host_legacy_cfg,
      .host_addr, .host_wdata, .host_no_snoop, .host_peer, .cfg_done, .cfg_rdata, .cfg_error, .mem_wr_valid,
      .mem_wr_addr, .mem_wr_data, .ur_sent, .wr_dropped, .msi_valid, .msi_data, .link_width, .link_rate,
      .link_trained, .lnk(lnk));
   endpoint_end endpoint_end_i (.clk, .reset_n, .dev_present, .dev_lanes, .dev_rates, .cfg_retry, .usr_valid,
      .usr_ready, .usr_kind, .usr_addr, .usr_data, .rx_valid, .rx_tlp, .ep_enc, .lnk(lnk));
   link_assertions link_assertions_i (.clk, .reset_n, .present(lnk.present), .lanes_offered(lnk.lanes_offered),
      .rates_offered(lnk.rates_offered), .link_up(lnk.link_up), .width(lnk.width), .rate(lnk.rate),
      .enc(lnk.enc), .dn_tlp(lnk.dn_tlp), .dn_valid(lnk.dn_valid), .up_tlp(lnk.up_tlp),
      .up_valid(lnk.up_valid), .up_ready(lnk.up_ready));
   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   function automatic int top_bit(input logic [4:0] v);
      top_bit = 0;
      for (int i = 0; i < 5; i++) if (v[i]) top_bit = i;
   endfunction
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      comparisons++;
      if (exp !== got) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Settled outputs looked at mid-cycle
   always @(negedge clk) begin
      n_wr += mem_wr_valid;
      n_drop += wr_dropped;
      n_ur += ur_sent;
      n_msi += msi_valid;
      if (rx_valid === 1'b1) begin
         if (rx_tlp.kind inside {TLP_CFG_RD, TLP_CFG_WR}) n_cfg++;
         else if (exp_q.size() == 0) chk("rx extra", 0, 1);
         else begin
            chk("rx addr", exp_q[0].addr, rx_tlp.addr);
            chk("rx data", exp_q[0].data, rx_tlp.data);
            chk("rx flags", {exp_q[0].no_snoop, exp_q[0].relaxed, exp_q[0].peer, exp_q[0].vc},
               {rx_tlp.no_snoop, rx_tlp.relaxed, rx_tlp.peer, rx_tlp.vc});
            void'(exp_q.pop_front());
         end
      end
   end
   task automatic train(input logic [4:0] l, input logic [2:0] r);
      int n;
      reset_n = 0;
      dev_lanes = l;
      dev_rates = r;
      repeat (5) @(negedge clk);
      reset_n = 1;
      n = 0;
      while (link_trained !== 1'b1 && n < 60) begin
         @(negedge clk);
         n++;
      end
      chk("trained", 1, link_trained);
      chk("width", top_bit(l), link_width);
      chk("rate", top_bit({2'h0, r}), link_rate);
      chk("enc", r[2], ep_enc);
   endtask
   // Request held until the edge that takes it
   task automatic host_req(input logic w, c, lg, input logic [63:0] ad, input logic [31:0] d, input logic ns, pr);
      int n;
      @(negedge clk);
      {host_write, host_cfg, host_legacy_cfg, host_no_snoop, host_peer} = {w, c, lg, ns, pr};
      host_addr = ad;
      host_wdata = d;
      host_valid = 1;
      n = 0;
      #1;
      while (host_ready !== 1'b1 && n < 200) begin
         @(negedge clk);
         #1;
         n++;
      end
      @(posedge clk);
   endtask
   task automatic dn_wr(input logic [63:0] ad, input logic [31:0] d, input logic ns, pr);
      e = '0;
      e.addr = {28'h0, ad[35:0]};
      e.data = d;
      e.no_snoop = ns;
      e.relaxed = ns;
      e.peer = pr;
      exp_q.push_back(e);
      host_req(1, 0, 0, ad, d, ns, pr);
   endtask
   task automatic cfg_access(input logic w, lg, input logic [63:0] ad, input logic rt, input int n_tlps,
      input logic [31:0] d);
      int n, c0;
      @(negedge clk);
      cfg_retry = rt;
      c0 = n_cfg;
      host_req(w, 1, lg, ad, d, 0, 0);
      @(negedge clk);
      host_valid = 0;
      n = 0;
      while (cfg_done !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      chk("cfg done", 1, cfg_done);
      chk("cfg error", rt, cfg_error);
      chk("cfg requests", n_tlps, n_cfg - c0);
      if (!w && !rt) chk("cfg rdata", d, cfg_rdata);
      cfg_retry = 0;
   endtask
   task automatic up_req(input tlp_t k, input logic [63:0] ad, input logic [31:0] d, input int ew, ed, eu, em);
      int w0, d0, u0, m0, n;
      @(negedge clk);
      {w0, d0, u0, m0} = {n_wr, n_drop, n_ur, n_msi};
      usr_kind = k;
      usr_addr = ad;
      usr_data = d;
      usr_valid = 1;
      n = 0;
      #1;
      while (usr_ready !== 1'b1 && n < 100) begin
         @(negedge clk);
         #1;
         n++;
      end
      @(posedge clk);
      @(negedge clk);
      usr_valid = 0;
      n = 0;
      while (n_wr + n_drop + n_ur + n_msi == w0 + d0 + u0 + m0 && n < 30) begin
         @(negedge clk);
         n++;
      end
      repeat (2) @(negedge clk);
      chk("mem writes", ew, n_wr - w0);
      chk("dropped", ed, n_drop - d0);
      chk("unsupported", eu, n_ur - u0);
      chk("msi", em, n_msi - m0);
      if (ew) chk("mem addr", ad, mem_wr_addr);
      if (ew) chk("mem data", d, mem_wr_data);
      if (em) chk("msi data", d, msi_data);
   endtask
   initial begin
      #2_000_000;
      err_total++;
      final_report();
   end
   initial begin
      {err_total, comparisons, n_wr, n_drop, n_ur, n_msi, n_cfg} = '0;
      seed = 74498;
      {reset_n, host_valid, host_write, host_cfg, host_legacy_cfg, host_no_snoop, host_peer} = '0;
      {host_addr, host_wdata, usr_addr, usr_data, usr_valid, cfg_retry, dev_present} = '0;
      dev_lanes = 5'h10;
      dev_rates = 3'h4;
      usr_kind = TLP_MEM_WR;
      repeat (5) @(negedge clk);
      reset_n = 1;
      repeat (40) @(negedge clk);
      chk("no device", 0, link_trained);
      dev_present = 1;
      for (int i = 0; i < 9; i++) begin
         lanes = (i < 5) ? 5'h1 << i : 5'($random(seed)) | 5'h1;
         rates = (i < 3) ? 3'h1 << i : 3'($random(seed)) | 3'h1;
         train(lanes, rates);
      end
      train(5'h1F, 3'h7);
      // Back-to-back burst of ten writes streams through the 4-word FIFO
      for (int i = 0; i < 10; i++) dn_wr({28'($random(seed)), 32'($random(seed)), 4'h0}, $random(seed), i[0], i == 3);
      host_req(0, 0, 0, 64'h100, 32'h0, 0, 1);
      @(negedge clk);
      host_valid = 0;
      repeat (40) @(negedge clk);
      chk("dn drained", 0, exp_q.size());
      d0 = $random(seed);
      d1 = $random(seed);
      cfg_access(1, 1, 64'hFC, 0, 1, d0);
      cfg_access(0, 0, 64'hFC, 0, 1, d0);
      cfg_access(1, 0, {52'h0, CFG_EXT_BASE}, 0, 1, d1);
      cfg_access(0, 0, {52'h0, CFG_EXT_BASE}, 0, 1, d1);
      cfg_access(0, 1, 64'hFFC, 0, 1, d0);
      cfg_access(0, 0, 64'h40, 1, MAX_CFG_RETRY + 1, 32'h0);
      up_req(TLP_MEM_WR, 64'hF_FFFF_FFFC, 32'hA5A5_5A5A, 1, 0, 0, 0);
      for (int i = 0; i < 12; i++) begin
         hi = (i < 4) ? 28'h1 : 28'($random(seed)) | 28'h1;
         a = {28'h0, 32'($random(seed)), 4'h0};
         case (i % 4)
            0: up_req(TLP_MEM_WR, a, $random(seed), 1, 0, 0, 0);
            1: up_req(TLP_MEM_WR, {hi, a[35:0]}, $random(seed), 0, 1, 0, 0);
            2: up_req(TLP_MEM_RD, {hi, a[35:0]}, $random(seed), 0, 0, 1, 0);
            default: up_req(TLP_MSG_MSI, a, $random(seed), 0, 0, 0, 1);
         endcase
      end
      final_report();
   end
endmodule
